// ==== include/timer_extint_pkg.sv ====
// timer and external interrupt control register: shared constants.
// assumes the register sits on an Avalon-MM slave with byte addresses.
// ---------------------------------------------------------------------
// Overview of operation
// - timer one overflow sets control bit 7.
// - timer zero overflow sets control bit 5.
// - each overflow flag clears when the processor vectors to its routine.
// - bit 6 runs timer one while one, stops it while zero.
// - bit 4 runs timer zero while one, stops it while zero.
// - a detected condition on external pin one sets bit 3.
// - a detected condition on external pin zero sets bit 1.
// - each external request flag clears once its interrupt is processed, unless its detector still sees a condition.
// - trigger-type bit zero (bits 2, 0) selects low-level triggering.
// - trigger-type bit one selects edge triggering, edge set by polarity.
// - reset clears all eight control bits to zero.
// - polarity bit zero means falling edge, one means rising, per pin.
// - overflow is roll-over to zero; a set flag raises a request.
// ---------------------------------------------------------------------
package timer_extint_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_OFFSET = 8'h88;
  localparam logic [7:0] POLARITY_OFFSET = 8'h8C;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] POLARITY_RESET = 2'h0;
  // control register field positions
  localparam int unsigned TIMER_ONE_OVF_BIT = 7;
  localparam int unsigned TIMER_ONE_RUN_BIT = 6;
  localparam int unsigned TIMER_ZERO_OVF_BIT = 5;
  localparam int unsigned TIMER_ZERO_RUN_BIT = 4;
  localparam int unsigned EXTIRQ_ONE_REQ_BIT = 3;
  localparam int unsigned EXTIRQ_ONE_TYPE_BIT = 2;
  localparam int unsigned EXTIRQ_ZERO_REQ_BIT = 1;
  localparam int unsigned EXTIRQ_ZERO_TYPE_BIT = 0;
  // polarity register field positions
  localparam int unsigned POL_ZERO_BIT = 0;
  localparam int unsigned POL_ONE_BIT = 1;
  // bus answer state, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_e;
endpackage

// ==== include/reg_access_if.sv ====
// register access carrier between the bus slave and the register core.
// assumes one clock; the core answers reads combinationally.
`timescale 1ns/1ps
interface reg_access_if;
  logic [7:0] addr;
  logic inRange;
  logic wrStrobe;
  logic [7:0] wrData;
  logic [7:0] rdData;
  // slave side drives the access, core side returns read data
  modport bus (output addr, output inRange, output wrStrobe, output wrData, input rdData);
  modport core (input addr, input inRange, input wrStrobe, input wrData, output rdData);
endinterface

// ==== rtl/extirq_detect.sv ====
// condition detector for one external interrupt pin.
// assumes the pin is synchronous to the clock.
`timescale 1ns/1ps
module extirq_detect (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // pin and mode
  input wire logic pin,
  input wire logic edgeMode,
  input wire logic risingSel,
  // result
  output logic detect
);
  logic pinPrev_q;

  // previous level; idles high so reset gives no false rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinPrev_q <= 1'b1;
    end else if (ce) begin
      pinPrev_q <= pin;
    end
  end

  // level mode is active low, edge mode picks the sense
  always_comb begin
    if (edgeMode) begin
      detect = risingSel ? (pin & ~pinPrev_q) : (~pin & pinPrev_q);
    end else begin
      detect = ~pin;
    end
  end
endmodule

// ==== rtl/avmm_reg_slave.sv ====
// Avalon-MM slave front end: one wait state, then a one-cycle answer.
// assumes the master holds its request until it sees waitrequest low.
`timescale 1ns/1ps
module avmm_reg_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // avalon slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // register core
  reg_access_if.bus regs
);
  timer_extint_pkg::bus_state_e state_q;

  if (ADDR_W < 8) begin : g_chk
    $error("avmm_reg_slave: ADDR_W must be at least 8");
  end

  // only byte lane 0 carries register data
  assign regs.addr = address[7:0];
  assign regs.inRange = ((address >> 8) == '0);
  assign regs.wrData = writedata[7:0];
  assign regs.wrStrobe = ce && write && byteenable[0] && (state_q == timer_extint_pkg::BUS_ANSWER);

  // answer one cycle after the request; write lands on the low edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= timer_extint_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else if (ce) begin
      case (state_q)
        timer_extint_pkg::BUS_IDLE: begin
          if (read || write) begin
            state_q <= timer_extint_pkg::BUS_ANSWER;
            waitrequest <= 1'b0;
            readdata <= read ? {24'h00_0000, regs.rdData} : 32'h0000_0000;
          end
        end
        timer_extint_pkg::BUS_ANSWER: begin
          state_q <= timer_extint_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          state_q <= timer_extint_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== rtl/timer_extint_control_reg.sv ====
// timer and external interrupt control register with its flag logic.
// holds run bits, overflow flags, trigger types, request flags and the
// edge polarity of both external pins.
// assumes the timers report roll-over as one-cycle pulses and the
// interrupt controller pulses an acknowledge when it vectors.
`timescale 1ns/1ps
module timer_extint_control_reg #(
  parameter int ADDR_W = 8,
  parameter int NUM_EXTIRQ = 2
) (
  // clock, reset and clock enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,

  // avalon-mm register port
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,

  // timer overflow events (roll-over pulses)
  input wire logic timerOneRollover,
  input wire logic timerZeroRollover,

  // interrupt controller acknowledges
  input wire logic timerOneVectorAck,
  input wire logic timerZeroVectorAck,
  input wire logic extirqOneProcessedAck,
  input wire logic extirqZeroProcessedAck,

  // external interrupt pins
  input wire logic extirqOnePin,
  input wire logic extirqZeroPin,

  // timer run controls
  output logic timerOneRun,
  output logic timerZeroRun,

  // interrupt requests (the flags themselves)
  output logic timerOneOverflowFlag,
  output logic timerZeroOverflowFlag,
  output logic extirqOneRequestFlag,
  output logic extirqZeroRequestFlag
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------

  // the register has exactly two external interrupt channels
  if (NUM_EXTIRQ != 2) begin : g_chk_irq
    $error("timer_extint_control_reg: NUM_EXTIRQ must be 2");
  end

  // the register map needs a full byte of address
  if (ADDR_W < 8) begin : g_chk_addr
    $error("timer_extint_control_reg: ADDR_W must be at least 8");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------

  reg_access_if regs ();

  logic timerOneOverflowFlag_q;
  logic timerOneRun_q;
  logic timerZeroOverflowFlag_q;
  logic timerZeroRun_q;
  logic extirqOneRequestFlag_q;
  logic extirqOneTriggerType_q;
  logic extirqZeroRequestFlag_q;
  logic extirqZeroTriggerType_q;
  logic extirqOneEdgePolarity_q;
  logic extirqZeroEdgePolarity_q;

  logic ctrlWrite;
  logic polarityWrite;
  logic [7:0] ctrlValue;
  logic [1:0] polarityValue;

  // per-channel views, index 0 is pin zero, index 1 is pin one
  logic [NUM_EXTIRQ-1:0] irqPin;
  logic [NUM_EXTIRQ-1:0] irqEdgeMode;
  logic [NUM_EXTIRQ-1:0] irqRising;
  logic [NUM_EXTIRQ-1:0] irqDetect;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------

  // true when an in-range byte address hits the given register
  function automatic logic addrIs(input logic inRange, input logic [7:0] addr,
                                  input logic [7:0] offset);
    addrIs = inRange && (addr == offset);
  endfunction

  // write strobes per register; unmapped writes fall through unused
  assign ctrlWrite = regs.wrStrobe && addrIs(regs.inRange, regs.addr,
                                             timer_extint_pkg::CTRL_OFFSET);
  assign polarityWrite = regs.wrStrobe && addrIs(regs.inRange, regs.addr,
                                                 timer_extint_pkg::POLARITY_OFFSET);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------

  // one wait state per access keeps the read mux off the bus path
  avmm_reg_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .regs(regs.bus)
  );

  // ---------------------------------------------------------------
  // register image and read-back
  // ---------------------------------------------------------------

  // control register as software sees it
  always_comb begin
    ctrlValue = 8'h00;
    ctrlValue[timer_extint_pkg::TIMER_ONE_OVF_BIT] = timerOneOverflowFlag_q;
    ctrlValue[timer_extint_pkg::TIMER_ONE_RUN_BIT] = timerOneRun_q;
    ctrlValue[timer_extint_pkg::TIMER_ZERO_OVF_BIT] = timerZeroOverflowFlag_q;
    ctrlValue[timer_extint_pkg::TIMER_ZERO_RUN_BIT] = timerZeroRun_q;
    ctrlValue[timer_extint_pkg::EXTIRQ_ONE_REQ_BIT] = extirqOneRequestFlag_q;
    ctrlValue[timer_extint_pkg::EXTIRQ_ONE_TYPE_BIT] = extirqOneTriggerType_q;
    ctrlValue[timer_extint_pkg::EXTIRQ_ZERO_REQ_BIT] = extirqZeroRequestFlag_q;
    ctrlValue[timer_extint_pkg::EXTIRQ_ZERO_TYPE_BIT] = extirqZeroTriggerType_q;
  end

  // polarity register; upper bits read as zero
  always_comb begin
    polarityValue = 2'h0;
    polarityValue[timer_extint_pkg::POL_ZERO_BIT] = extirqZeroEdgePolarity_q;
    polarityValue[timer_extint_pkg::POL_ONE_BIT] = extirqOneEdgePolarity_q;
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    if (addrIs(regs.inRange, regs.addr, timer_extint_pkg::CTRL_OFFSET)) begin
      regs.rdData = ctrlValue;
    end else if (addrIs(regs.inRange, regs.addr, timer_extint_pkg::POLARITY_OFFSET)) begin
      regs.rdData = {6'h00, polarityValue};
    end else begin
      regs.rdData = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // timer run controls
  // ---------------------------------------------------------------

  // run bits are plain software controls that steer the timers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timerOneRun_q <= timer_extint_pkg::CTRL_RESET[timer_extint_pkg::TIMER_ONE_RUN_BIT];
      timerZeroRun_q <= timer_extint_pkg::CTRL_RESET[timer_extint_pkg::TIMER_ZERO_RUN_BIT];
    end else if (ce && ctrlWrite) begin
      timerOneRun_q <= regs.wrData[timer_extint_pkg::TIMER_ONE_RUN_BIT];
      timerZeroRun_q <= regs.wrData[timer_extint_pkg::TIMER_ZERO_RUN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // timer overflow flags
  // ---------------------------------------------------------------

  // order matters: write, then vector clear, then roll-over set, so a
  // roll-over in the clearing cycle is never lost
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timerOneOverflowFlag_q <= timer_extint_pkg::CTRL_RESET[timer_extint_pkg::TIMER_ONE_OVF_BIT];
    end else if (ce) begin
      if (timerOneRollover) begin
        timerOneOverflowFlag_q <= 1'b1;
      end else if (timerOneVectorAck) begin
        timerOneOverflowFlag_q <= 1'b0;
      end else if (ctrlWrite) begin
        timerOneOverflowFlag_q <= regs.wrData[timer_extint_pkg::TIMER_ONE_OVF_BIT];
      end
    end
  end

  // same priority for timer zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timerZeroOverflowFlag_q <= timer_extint_pkg::CTRL_RESET[timer_extint_pkg::TIMER_ZERO_OVF_BIT];
    end else if (ce) begin
      if (timerZeroRollover) begin
        timerZeroOverflowFlag_q <= 1'b1;
      end else if (timerZeroVectorAck) begin
        timerZeroOverflowFlag_q <= 1'b0;
      end else if (ctrlWrite) begin
        timerZeroOverflowFlag_q <= regs.wrData[timer_extint_pkg::TIMER_ZERO_OVF_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // trigger types and edge polarity
  // ---------------------------------------------------------------

  // trigger type picks level or edge for each pin
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extirqOneTriggerType_q <= timer_extint_pkg::CTRL_RESET[timer_extint_pkg::EXTIRQ_ONE_TYPE_BIT];
      extirqZeroTriggerType_q <=
        timer_extint_pkg::CTRL_RESET[timer_extint_pkg::EXTIRQ_ZERO_TYPE_BIT];
    end else if (ce && ctrlWrite) begin
      extirqOneTriggerType_q <= regs.wrData[timer_extint_pkg::EXTIRQ_ONE_TYPE_BIT];
      extirqZeroTriggerType_q <= regs.wrData[timer_extint_pkg::EXTIRQ_ZERO_TYPE_BIT];
    end
  end

  // polarity only matters in edge mode; reset selects falling edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extirqZeroEdgePolarity_q <= timer_extint_pkg::POLARITY_RESET[timer_extint_pkg::POL_ZERO_BIT];
      extirqOneEdgePolarity_q <= timer_extint_pkg::POLARITY_RESET[timer_extint_pkg::POL_ONE_BIT];
    end else if (ce && polarityWrite) begin
      extirqZeroEdgePolarity_q <= regs.wrData[timer_extint_pkg::POL_ZERO_BIT];
      extirqOneEdgePolarity_q <= regs.wrData[timer_extint_pkg::POL_ONE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // external interrupt detection
  // ---------------------------------------------------------------

  // gather both channels so one detector serves each
  assign irqPin = {extirqOnePin, extirqZeroPin};
  assign irqEdgeMode = {extirqOneTriggerType_q, extirqZeroTriggerType_q};
  assign irqRising = {extirqOneEdgePolarity_q, extirqZeroEdgePolarity_q};

  // one detector per pin
  for (genvar i = 0; i < NUM_EXTIRQ; i++) begin : g_detect
    extirq_detect u_detect (
      .clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .pin(irqPin[i]),
      .edgeMode(irqEdgeMode[i]),
      .risingSel(irqRising[i]),
      .detect(irqDetect[i])
    );
  end

  // ---------------------------------------------------------------
  // external request flags
  // ---------------------------------------------------------------

  // detection beats the processed clear; a held low level in level
  // mode therefore keeps the flag up, which is the intended behaviour
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extirqOneRequestFlag_q <= timer_extint_pkg::CTRL_RESET[timer_extint_pkg::EXTIRQ_ONE_REQ_BIT];
    end else if (ce) begin
      if (irqDetect[1]) begin
        extirqOneRequestFlag_q <= 1'b1;
      end else if (extirqOneProcessedAck) begin
        extirqOneRequestFlag_q <= 1'b0;
      end else if (ctrlWrite) begin
        extirqOneRequestFlag_q <= regs.wrData[timer_extint_pkg::EXTIRQ_ONE_REQ_BIT];
      end
    end
  end

  // same priority for pin zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extirqZeroRequestFlag_q <=
        timer_extint_pkg::CTRL_RESET[timer_extint_pkg::EXTIRQ_ZERO_REQ_BIT];
    end else if (ce) begin
      if (irqDetect[0]) begin
        extirqZeroRequestFlag_q <= 1'b1;
      end else if (extirqZeroProcessedAck) begin
        extirqZeroRequestFlag_q <= 1'b0;
      end else if (ctrlWrite) begin
        extirqZeroRequestFlag_q <= regs.wrData[timer_extint_pkg::EXTIRQ_ZERO_REQ_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // every output is a flop; flags double as interrupt requests
  assign timerOneRun = timerOneRun_q;
  assign timerZeroRun = timerZeroRun_q;
  assign timerOneOverflowFlag = timerOneOverflowFlag_q;
  assign timerZeroOverflowFlag = timerZeroOverflowFlag_q;
  assign extirqOneRequestFlag = extirqOneRequestFlag_q;
  assign extirqZeroRequestFlag = extirqZeroRequestFlag_q;

endmodule

// ==== sim/timer_extint_control_reg_asserts.sv ====
// port checker for the timer and external interrupt control register.
// assumes one clock domain and a bus master that holds each request.
`timescale 1ns/1ps
module timer_extint_control_reg_asserts #(
  parameter int ADDR_W = 8,
  parameter int NUM_EXTIRQ = 2
) (
  // clock, reset and enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // avalon slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // events and pins
  input wire logic timerOneRollover,
  input wire logic timerZeroRollover,
  input wire logic timerOneVectorAck,
  input wire logic timerZeroVectorAck,
  input wire logic extirqOneProcessedAck,
  input wire logic extirqZeroProcessedAck,
  input wire logic extirqOnePin,
  input wire logic extirqZeroPin,
  // register outputs
  input wire logic timerOneRun,
  input wire logic timerZeroRun,
  input wire logic timerOneOverflowFlag,
  input wire logic timerZeroOverflowFlag,
  input wire logic extirqOneRequestFlag,
  input wire logic extirqZeroRequestFlag
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // shadow of the mode bits
  // ----------------------------------------
  logic ctrlWr;
  logic polWr;
  logic [1:0] type_q;
  logic [1:0] pol_q;
  // accepted writes, decoded at the edge where waitrequest is low
  assign ctrlWr = write && !waitrequest && ce && byteenable[0]
    && (address == ADDR_W'(timer_extint_pkg::CTRL_OFFSET));
  assign polWr = write && !waitrequest && ce && byteenable[0]
    && (address == ADDR_W'(timer_extint_pkg::POLARITY_OFFSET));
  // only software moves type and polarity, so a shadow can follow them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      type_q <= 2'h0;
      pol_q <= 2'h0;
    end else begin
      if (ctrlWr) type_q <= {writedata[2], writedata[0]};
      if (polWr) pol_q <= writedata[1:0];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ovf_one_set_a: assert property (timerOneRollover && ce |=> timerOneOverflowFlag)
    else $error("timer one overflow flag not set");
  ovf_zero_set_a: assert property (timerZeroRollover && ce |=> timerZeroOverflowFlag)
    else $error("timer zero overflow flag not set");
  vector_clear_a: assert property (( timerOneVectorAck && !timerOneRollover && ce
    |=> !timerOneOverflowFlag) and (timerZeroVectorAck && !timerZeroRollover && ce
    |=> !timerZeroOverflowFlag)) else $error("overflow flag not cleared by vector");
  run_write_a: assert property (ctrlWr |=> timerOneRun == $past(writedata[6])
    && timerZeroRun == $past(writedata[4])) else $error("run bits not written");
  run_hold_a: assert property (!ctrlWr |=> $stable(timerOneRun) && $stable(timerZeroRun))
    else $error("run bit moved without a write");
  level_set_a: assert property (!type_q[0] && !extirqZeroPin && ce
    |=> extirqZeroRequestFlag) else $error("low level did not set request");
  edge_set_a: assert property (type_q[1] && ce && (pol_q[1] ? $rose(extirqOnePin)
    : $fell(extirqOnePin)) |=> extirqOneRequestFlag) else $error("edge did not set request");
  req_clear_a: assert property (extirqOneProcessedAck && ce && extirqOnePin
    && $past(extirqOnePin) |=> !extirqOneRequestFlag) else $error("request not cleared");
  reset_state_a: assert property ($rose(resetn) |-> waitrequest && readdata == 32'h0
    && !timerOneRun && !timerZeroRun && !timerOneOverflowFlag && !timerZeroOverflowFlag
    && !extirqOneRequestFlag && !extirqZeroRequestFlag) else $error("bad state after reset");
  answer_once_a: assert property (!waitrequest && ce |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  answer_next_a: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("access not answered after one wait state");
  unmapped_read_a: assert property (read && !waitrequest && !polWr && address != ADDR_W'(8'h88)
    && address != ADDR_W'(8'h8C) |-> readdata == 32'h0) else $error("unmapped read not zero");
  // main scenarios
  cover property (timerOneRollover && timerOneVectorAck);
  cover property (ctrlWr && writedata[7]);
  cover property (type_q[1] && pol_q[1] && extirqOneRequestFlag);
endmodule

bind timer_extint_control_reg timer_extint_control_reg_asserts #(.ADDR_W(ADDR_W),
  .NUM_EXTIRQ(NUM_EXTIRQ)) i_timer_extint_control_reg_asserts (.core_clk(core_clk),
  .resetn(resetn), .ce(ce), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .timerOneRollover(timerOneRollover),
  .timerZeroRollover(timerZeroRollover), .timerOneVectorAck(timerOneVectorAck),
  .timerZeroVectorAck(timerZeroVectorAck), .extirqOneProcessedAck(extirqOneProcessedAck),
  .extirqZeroProcessedAck(extirqZeroProcessedAck), .extirqOnePin(extirqOnePin),
  .extirqZeroPin(extirqZeroPin), .timerOneRun(timerOneRun), .timerZeroRun(timerZeroRun),
  .timerOneOverflowFlag(timerOneOverflowFlag), .timerZeroOverflowFlag(timerZeroOverflowFlag),
  .extirqOneRequestFlag(extirqOneRequestFlag), .extirqZeroRequestFlag(extirqZeroRequestFlag));

// ==== sim/timer_extint_control_reg_bench.sv ====
// self-checking bench for the timer and external interrupt control register.
// assumes the package is compiled first and ce may stay high throughout.
`timescale 1ns/1ps
module timer_extint_control_reg_bench;
  localparam logic [7:0] CTRL = timer_extint_pkg::CTRL_OFFSET;
  localparam logic [7:0] POL = timer_extint_pkg::POLARITY_OFFSET;
  logic coreClk;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [5:0] ev = 6'h00;
  logic [1:0] pin = 2'h3;
  logic [1:0] req;
  logic runOne, runZero, ovfOne, ovfZero;
  logic [31:0] q;
  int nFail = 0;
  int samplesChecked = 0;
  int cycles = 0;
  // ev: 0/1 roll-over, 2/3 vector ack, 4/5 processed ack (one, zero)
  timer_extint_control_reg i_timer_extint_control_reg (.core_clk(coreClk), .resetn(resetn),
    .ce(1'b1), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .timerOneRollover(ev[0]), .timerZeroRollover(ev[1]), .timerOneVectorAck(ev[2]),
    .timerZeroVectorAck(ev[3]), .extirqOneProcessedAck(ev[4]),
    .extirqZeroProcessedAck(ev[5]), .extirqOnePin(pin[1]), .extirqZeroPin(pin[0]),
    .timerOneRun(runOne), .timerZeroRun(runZero), .timerOneOverflowFlag(ovfOne),
    .timerZeroOverflowFlag(ovfZero), .extirqOneRequestFlag(req[1]),
    .extirqZeroRequestFlag(req[0]));
  // ----------------------------------------
  // clock, timeout and report
  // ----------------------------------------
  initial begin
    coreClk = 1'b0;
    forever #2.5 coreClk = ~coreClk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      nFail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic checkFlag(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: output %b, wanted %b", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // bus and event drivers
  // ----------------------------------------
  // request held until waitrequest is seen low, released at that edge, then one idle edge
  task automatic busCycle(input logic isWr, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] r);
    int n = 0;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !isWr;
    write <= isWr;
    do begin
      @(posedge coreClk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    r = readdata;
    if (n >= 20) checkFlag(waitrequest, 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge coreClk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busCycle(1'b1, a, d, 4'h1, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    busCycle(1'b0, a, 8'h00, 4'hF, q);
    checkWord(q, exp);
  endtask
  // one-cycle pulse on the chosen event inputs
  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge coreClk);
    ev <= 6'h00;
    @(posedge coreClk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge coreClk);
    resetn <= 1'b1;
    @(posedge coreClk);
    checkFlag(ovfOne | ovfZero | req[0] | req[1] | runOne | runZero, 1'b0);
    rdChk(CTRL, 32'h0);
    rdChk(POL, 32'h0);
    // run bits, a lane-0-off write and an unmapped place
    wr(CTRL, 8'h50);
    checkFlag(runOne & runZero, 1'b1);
    wr(CTRL, 8'h10);
    checkFlag(runOne, 1'b0);
    checkFlag(runZero, 1'b1);
    busCycle(1'b1, CTRL, 8'hFF, 4'h0, q);
    rdChk(CTRL, 32'h10);
    wr(8'h90, 8'hFF);
    rdChk(8'h90, 32'h0);
    wr(CTRL, 8'h00);
    // overflow set, vector clear, and set beating a same-cycle clear
    for (int i = 0; i < 2; i++) begin
      pulse(6'h01 << i);
      rdChk(CTRL, (i == 1) ? 32'h20 : 32'h80);
      pulse(6'h04 << i);
      checkFlag((i == 1) ? ovfZero : ovfOne, 1'b0);
      pulse(6'h05 << i);
      checkFlag((i == 1) ? ovfZero : ovfOne, 1'b1);
      pulse(6'h04 << i);
    end
    // level mode: low pin sets, clear only sticks with the pin high
    for (int j = 0; j < 2; j++) begin
      pin[j] <= 1'b0;
      repeat (2) @(posedge coreClk);
      checkFlag(req[j], 1'b1);
      rdChk(CTRL, (j == 1) ? 32'h08 : 32'h02);
      pin[j] <= 1'b1;
      pulse((j == 1) ? 6'h10 : 6'h20);
      checkFlag(req[j], 1'b0);
    end
    // edge mode, falling polarity, then rising polarity
    wr(CTRL, 8'h05);
    for (int j = 0; j < 2; j++) begin
      pin[j] <= 1'b0;
      repeat (2) @(posedge coreClk);
      checkFlag(req[j], 1'b1);
      pulse((j == 1) ? 6'h10 : 6'h20);
      checkFlag(req[j], 1'b0);
      pin[j] <= 1'b1;
      repeat (2) @(posedge coreClk);
      checkFlag(req[j], 1'b0);
    end
    wr(POL, 8'h03);
    rdChk(POL, 32'h03);
    for (int j = 0; j < 2; j++) begin
      pin[j] <= 1'b0;
      repeat (2) @(posedge coreClk);
      checkFlag(req[j], 1'b0);
      pin[j] <= 1'b1;
      repeat (2) @(posedge coreClk);
      checkFlag(req[j], 1'b1);
      pulse((j == 1) ? 6'h10 : 6'h20);
      checkFlag(req[j], 1'b0);
    end
    // software sets and clears every flag directly
    wr(CTRL, 8'hAA);
    checkFlag(ovfOne & ovfZero & req[0] & req[1], 1'b1);
    rdChk(CTRL, 32'hAA);
    wr(CTRL, 8'h00);
    rdChk(CTRL, 32'h00);
    // reset in mid-run clears what software left behind
    wr(CTRL, 8'h50);
    resetn <= 1'b0;
    @(posedge coreClk);
    resetn <= 1'b1;
    @(posedge coreClk);
    checkFlag(runOne | runZero, 1'b0);
    rdChk(CTRL, 32'h0);
    stop_test();
  end
endmodule
